/* include/ssim_pkg.sv */
// Constants of the serial controller interrupt mask logic.
// Assumes one peripheral clock and the plain register port of the top module.
package ssim_pkg;

  // ----------------------------------------
  // Bus widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 12;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IER    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IDR    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EVCLR  = 8'h10;

  // ----------------------------------------
  // Flag positions, shared by status and mask; bits 16 and 17 are status only
  // ----------------------------------------
  localparam int unsigned B_TX_FREE  = 0;
  localparam int unsigned B_TX_DRAIN = 1;
  localparam int unsigned B_TX_DONE  = 2;
  localparam int unsigned B_TX_BUFE  = 3;
  localparam int unsigned B_RX_FULL  = 4;
  localparam int unsigned B_OVERRUN  = 5;
  localparam int unsigned B_RX_DONE  = 6;
  localparam int unsigned B_RX_BUFF  = 7;
  localparam int unsigned B_CMP0     = 8;
  localparam int unsigned B_CMP1     = 9;
  localparam int unsigned B_TX_SYNC  = 10;
  localparam int unsigned B_RX_SYNC  = 11;
  localparam int unsigned B_TX_ON    = 16;
  localparam int unsigned B_RX_ON    = 17;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [FLAG_W-1:0] MASK_RST    = 12'h000;
  localparam logic              TX_FREE_RST = 1'b1;
  localparam logic [4:0]        EVT_RST     = 5'h00;
  localparam logic [2:0]        CNT_RST     = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST   = 32'h0000_0000;

endpackage : ssim_pkg

/* include/ssim_mask_if.sv */
// Carries mask updates from the register decode to the mask store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ssim_mask_if;
  import ssim_pkg::*;
  logic [FLAG_W-1:0] set_bits;
  logic [FLAG_W-1:0] clr_bits;
  logic [FLAG_W-1:0] mask;

  modport ctrl  (output set_bits, output clr_bits, input mask);
  modport store (input set_bits, input clr_bits, output mask);
endinterface : ssim_mask_if

/* hdl/ssim_sticky.sv */
// A row of sticky flags: set by hardware, cleared on request.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ns
module ssim_sticky #(
  parameter int unsigned  W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  // Set wins, so an event in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule : ssim_sticky

/* hdl/ssim_mask.sv */
// Mask store and interrupt line.
// Assumes set and clear bits are one-cycle pulses from the register decode.
`timescale 1ns/1ns
module ssim_mask import ssim_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rst_n,
  ssim_mask_if.store             m,
  input  wire logic [FLAG_W-1:0] flags,
  output logic                   irq
);

  // ----------------------------------------
  // Mask bits
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      m.mask <= MASK_RST;
    end else begin
      m.mask <= (m.mask & ~m.clr_bits) | m.set_bits; // RQ5 RQ6
    end
  end

  // ----------------------------------------
  // Interrupt line
  // ----------------------------------------
  // Registered so the output is glitch free; costs one cycle of latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & m.mask); // RQ12
    end
  end

endmodule : ssim_mask

/* hdl/ssim_top.sv */
// Interrupt mask logic of a synchronous serial controller.
// Assumes all event and level inputs come from datapath logic on CORE_CLK.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// RQ1 - Receive sync flag sets on its event and clears on a status read.
// RQ2 - Status bit shows whether the transmitter is enabled.
// RQ3 - Status bit shows whether the receiver is enabled.
// RQ4 - Set, clear and mask registers share one twelve-bit layout; rest reserved.
// RQ5 - Writing ones to enable-set sets those mask bits only.
// RQ6 - Writing ones to enable-clear clears those mask bits only.
// RQ7 - Mask view register returns the current mask.
// RQ8 - Holding-free flag is low while a written word waits for the shifter.
// RQ9 - Overrun sets when a word loads while the previous one is unread.
// RQ10 - Compare and transmit sync flags are sticky, cleared by status read.
// RQ11 - Transmit count done is high once counter reached zero since rewrite.
// RQ12 - Interrupt is high while any flag and its mask bit are both set.
module ssim_top import ssim_pkg::*; (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  output logic                   IRQ,
  input  wire logic              TX_WORD_WRITTEN,
  input  wire logic              TX_WORD_LOADED,
  input  wire logic              TX_SHIFT_IDLE,
  input  wire logic              TX_COUNT_ZERO,
  input  wire logic              TX_COUNT_WRITE,
  input  wire logic              TX_BUFS_EMPTY,
  input  wire logic              RX_WORD_LOADED,
  input  wire logic              RX_WORD_READ,
  input  wire logic              RX_COUNT_ZERO,
  input  wire logic              RX_COUNT_WRITE,
  input  wire logic              RX_BUFS_FULL,
  input  wire logic              CMP0_HIT,
  input  wire logic              CMP1_HIT,
  input  wire logic              TX_SYNC_HIT,
  input  wire logic              RX_SYNC_HIT,
  input  wire logic              TX_ENABLED,
  input  wire logic              RX_ENABLED
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic              status_rd;
  logic              mask_rd;
  logic              ier_wr;
  logic              idr_wr;
  logic              evclr_wr;
  logic              tx_free;
  logic [4:0]        evt_set;
  logic [4:0]        evt_clr;
  logic [4:0]        evt_q;
  logic [2:0]        cnt_set;
  logic [2:0]        cnt_clr;
  logic [2:0]        cnt_q;
  logic [FLAG_W-1:0] flags;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] next_rdata;

  ssim_mask_if mif ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    status_rd = 1'b0;
    mask_rd   = 1'b0;
    if (RD && ADDR == OFF_STATUS) begin
      status_rd = 1'b1;
    end else if (RD && ADDR == OFF_MASK) begin
      mask_rd = 1'b1;
    end
  end

  always_comb begin
    ier_wr   = 1'b0;
    idr_wr   = 1'b0;
    evclr_wr = 1'b0;
    if (WR && ADDR == OFF_IER) begin
      ier_wr = 1'b1;
    end else if (WR && ADDR == OFF_IDR) begin
      idr_wr = 1'b1;
    end else if (WR && ADDR == OFF_EVCLR) begin
      evclr_wr = 1'b1;
    end
  end

  // ----------------------------------------
  // Transmit holding state
  // ----------------------------------------
  // A write in the same cycle as a load leaves a fresh word waiting
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tx_free <= TX_FREE_RST;
    end else if (TX_WORD_WRITTEN) begin
      tx_free <= 1'b0; // RQ8
    end else if (TX_WORD_LOADED) begin
      tx_free <= 1'b1; // RQ8
    end
  end

  // ----------------------------------------
  // Sticky events
  // ----------------------------------------
  // Order: rx sync, tx sync, cmp1, cmp0, overrun
  assign evt_set = {RX_SYNC_HIT, TX_SYNC_HIT, CMP1_HIT, CMP0_HIT, // RQ1 RQ10
                    RX_WORD_LOADED & cnt_q[2]}; // RQ9
  assign evt_clr = {5{status_rd}}
                 | ({5{evclr_wr}} & {WDATA[B_RX_SYNC], WDATA[B_TX_SYNC],
                                     WDATA[B_CMP1], WDATA[B_CMP0], WDATA[B_OVERRUN]});

  ssim_sticky #(
    .W   (5),
    .RST (EVT_RST)
  ) u_evt (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .set   (evt_set),
    .clr   (evt_clr),
    .q     (evt_q)
  );

  // ----------------------------------------
  // Counter and receive holding flags
  // ----------------------------------------
  // Order: rx holding full, rx count done, tx count done
  assign cnt_set = {RX_WORD_LOADED, RX_COUNT_ZERO, TX_COUNT_ZERO}; // RQ11
  assign cnt_clr = {RX_WORD_READ, RX_COUNT_WRITE, TX_COUNT_WRITE}; // RQ11

  ssim_sticky #(
    .W   (3),
    .RST (CNT_RST)
  ) u_cnt (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .set   (cnt_set),
    .clr   (cnt_clr),
    .q     (cnt_q)
  );

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb begin
    flags             = '0;
    flags[B_TX_FREE]  = tx_free; // RQ8
    flags[B_TX_DRAIN] = tx_free & TX_SHIFT_IDLE;
    flags[B_TX_DONE]  = cnt_q[0]; // RQ11
    flags[B_TX_BUFE]  = TX_BUFS_EMPTY;
    flags[B_RX_FULL]  = cnt_q[2];
    flags[B_OVERRUN]  = evt_q[0]; // RQ9
    flags[B_RX_DONE]  = cnt_q[1];
    flags[B_RX_BUFF]  = RX_BUFS_FULL;
    flags[B_CMP0]     = evt_q[1]; // RQ10
    flags[B_CMP1]     = evt_q[2]; // RQ10
    flags[B_TX_SYNC]  = evt_q[3]; // RQ10
    flags[B_RX_SYNC]  = evt_q[4]; // RQ1
  end

  always_comb begin
    status_word             = '0;
    status_word[FLAG_W-1:0] = flags; // RQ4
    status_word[B_TX_ON]    = TX_ENABLED; // RQ2
    status_word[B_RX_ON]    = RX_ENABLED; // RQ3
  end

  // ----------------------------------------
  // Mask control
  // ----------------------------------------
  // Bits 12 and up of a write are reserved and dropped
  assign mif.set_bits = ier_wr ? WDATA[FLAG_W-1:0] : '0; // RQ5
  assign mif.clr_bits = idr_wr ? WDATA[FLAG_W-1:0] : '0; // RQ6

  ssim_mask u_mask (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .m     (mif),
    .flags (flags),
    .irq   (IRQ)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Write-only and unmapped offsets read as zero
  always_comb begin
    next_rdata = '0;
    if (status_rd) begin
      next_rdata = status_word;
    end else if (mask_rd) begin
      next_rdata = {{(DATA_W-FLAG_W){1'b0}}, mif.mask}; // RQ7
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RDATA <= RDATA_RST;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence ier_write_s;
    WR && ADDR == OFF_IER;
  endsequence

  sequence idr_write_s;
    WR && ADDR == OFF_IDR;
  endsequence

  sequence status_read_s;
    RD && ADDR == OFF_STATUS;
  endsequence

  rx_sync_set_a: assert property ( // RQ1
    RX_SYNC_HIT |=> flags[B_RX_SYNC]
  ) else $error("receive sync flag not set");

  rx_sync_clr_a: assert property ( // RQ1
    status_read_s ##0 !RX_SYNC_HIT |=> !flags[B_RX_SYNC]
  ) else $error("receive sync flag not cleared by status read");

  tx_on_read_a: assert property ( // RQ2
    status_read_s |=> RDATA[B_TX_ON] == $past(TX_ENABLED)
  ) else $error("transmitter enable bit wrong");

  rx_on_read_a: assert property ( // RQ3
    status_read_s |=> RDATA[B_RX_ON] == $past(RX_ENABLED)
  ) else $error("receiver enable bit wrong");

  reserved_zero_a: assert property ( // RQ4
    status_read_s |=> RDATA[31:18] == 14'h0000 && RDATA[15:12] == 4'h0
  ) else $error("reserved status bits not zero");

  mask_set_a: assert property ( // RQ5
    ier_write_s |=> (mif.mask & $past(WDATA[FLAG_W-1:0])) == $past(WDATA[FLAG_W-1:0])
                    && (mif.mask & ~$past(WDATA[FLAG_W-1:0]))
                       == ($past(mif.mask) & ~$past(WDATA[FLAG_W-1:0]))
  ) else $error("enable-set write wrong");

  mask_clr_a: assert property ( // RQ6
    idr_write_s |=> (mif.mask & $past(WDATA[FLAG_W-1:0])) == 12'h000
                    && (mif.mask & ~$past(WDATA[FLAG_W-1:0]))
                       == ($past(mif.mask) & ~$past(WDATA[FLAG_W-1:0]))
  ) else $error("enable-clear write wrong");

  mask_view_a: assert property ( // RQ7
    ier_write_s ##1 !WR ##1 (RD && ADDR == OFF_MASK)
      |=> (RDATA[FLAG_W-1:0] & $past(WDATA[FLAG_W-1:0], 3)) == $past(WDATA[FLAG_W-1:0], 3)
  ) else $error("mask view does not follow enable-set");

  tx_wait_a: assert property ( // RQ8
    TX_WORD_WRITTEN |=> !flags[B_TX_FREE]
                        ##1 (flags[B_TX_FREE] == ($past(TX_WORD_LOADED) && !$past(TX_WORD_WRITTEN)))
  ) else $error("holding-free flag wrong after write");

  overrun_a: assert property ( // RQ9
    RX_WORD_LOADED && flags[B_RX_FULL] |=> flags[B_OVERRUN]
  ) else $error("overrun not flagged");

  cmp_sticky_a: assert property ( // RQ10
    CMP0_HIT ##1 (!(RD && ADDR == OFF_STATUS) && !(WR && ADDR == OFF_EVCLR)) |=> flags[B_CMP0]
  ) else $error("compare flag not sticky");

  tx_done_a: assert property ( // RQ11
    TX_COUNT_WRITE && !TX_COUNT_ZERO |=> !flags[B_TX_DONE]
  ) else $error("count done not cleared by counter write");

  tx_done_set_a: assert property ( // RQ11
    TX_COUNT_ZERO |=> flags[B_TX_DONE]
  ) else $error("count done not set");

  irq_on_a: assert property ( // RQ12
    |(flags & mif.mask) |=> IRQ
  ) else $error("interrupt missing");

  irq_off_a: assert property ( // RQ12
    !(|(flags & mif.mask)) |=> !IRQ
  ) else $error("spurious interrupt");

  rx_sync_hold_a: assert property ( // RQ1
    flags[B_RX_SYNC] && !(RD && ADDR == OFF_STATUS) && !(WR && ADDR == OFF_EVCLR) |=> flags[B_RX_SYNC]
  ) else $error("receive sync flag lost without a clear");

  mask_reserved_a: assert property ( // RQ4
    (RD && ADDR == OFF_MASK) |=> RDATA[DATA_W-1:FLAG_W] == 20'h0_0000
  ) else $error("reserved mask view bits not zero");

  mask_hold_a: assert property ( // RQ5
    !(WR && (ADDR == OFF_IER || ADDR == OFF_IDR)) |=> $stable(mif.mask)
  ) else $error("mask changed without a write");

  mask_read_a: assert property ( // RQ7
    (RD && ADDR == OFF_MASK) |=> RDATA[FLAG_W-1:0] == $past(mif.mask)
  ) else $error("mask view differs from mask");

  tx_free_load_a: assert property ( // RQ8
    TX_WORD_LOADED && !TX_WORD_WRITTEN |=> flags[B_TX_FREE]
  ) else $error("holding-free flag not set after load");

  tx_free_hold_a: assert property ( // RQ8
    !flags[B_TX_FREE] && !TX_WORD_LOADED |=> !flags[B_TX_FREE]
  ) else $error("holding-free flag set while a word waits");

  rx_full_a: assert property ( // RQ9
    RX_WORD_LOADED |=> flags[B_RX_FULL]
  ) else $error("receive holding full not set");

  no_overrun_a: assert property ( // RQ9
    RX_WORD_LOADED && !flags[B_RX_FULL] && !flags[B_OVERRUN] |=> !flags[B_OVERRUN]
  ) else $error("overrun flagged on a first word");

  overrun_clr_a: assert property ( // RQ9
    status_read_s ##0 !(RX_WORD_LOADED && flags[B_RX_FULL]) |=> !flags[B_OVERRUN]
  ) else $error("overrun not cleared by status read");

  cmp1_set_a: assert property ( // RQ10
    CMP1_HIT |=> flags[B_CMP1]
  ) else $error("compare one flag not set");

  tx_sync_set_a: assert property ( // RQ10
    TX_SYNC_HIT |=> flags[B_TX_SYNC]
  ) else $error("transmit sync flag not set");

  sticky_read_clr_a: assert property ( // RQ10
    status_read_s ##0 (!CMP0_HIT && !CMP1_HIT && !TX_SYNC_HIT)
      |=> !flags[B_CMP0] && !flags[B_CMP1] && !flags[B_TX_SYNC]
  ) else $error("sticky flags not cleared by status read");

  evclr_cmp_a: assert property ( // RQ10
    WR && ADDR == OFF_EVCLR && WDATA[B_CMP0] && !CMP0_HIT |=> !flags[B_CMP0]
  ) else $error("compare flag not cleared by event clear");

  tx_done_hold_a: assert property ( // RQ11
    flags[B_TX_DONE] && !TX_COUNT_WRITE |=> flags[B_TX_DONE]
  ) else $error("count done lost without a counter write");

endmodule : ssim_top

/* tb/ssim_intc_model.sv */
// Interrupt controller model: counts assertions of the level interrupt.
// Assumes it runs on the same clock as the block.
`timescale 1ns/1ns
module ssim_intc_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       irq,
  output logic      [7:0] edges
);
  logic irq_d;

  // A level line counts once per assertion, as an edge-sensitive source would
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_d <= 1'b0;
      edges <= 8'h00;
    end else begin
      irq_d <= irq;
      if (irq && !irq_d) begin
        edges <= edges + 8'h01;
      end
    end
  end
endmodule : ssim_intc_model

/* tb/ssim_top_tb_top.sv */
// Testbench of the serial controller interrupt mask logic.
// Assumes register port and event inputs change just after CORE_CLK edges.
`timescale 1ns/1ns
module ssim_top_tb_top;
  import ssim_pkg::*;
  logic              core_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic [11:0]       ev;
  logic [4:0]        lv;
  logic [7:0]        edges;
  int                failures;
  int                total_checks;
  int                cycles = 0;

  ssim_top i_ssim_top (
    .CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .TX_WORD_WRITTEN(ev[0]), .TX_WORD_LOADED(ev[1]),
    .TX_SHIFT_IDLE(lv[0]), .TX_COUNT_ZERO(ev[2]), .TX_COUNT_WRITE(ev[3]), .TX_BUFS_EMPTY(lv[1]),
    .RX_WORD_LOADED(ev[4]), .RX_WORD_READ(ev[5]), .RX_COUNT_ZERO(ev[6]), .RX_COUNT_WRITE(ev[7]),
    .RX_BUFS_FULL(lv[2]), .CMP0_HIT(ev[8]), .CMP1_HIT(ev[9]), .TX_SYNC_HIT(ev[10]),
    .RX_SYNC_HIT(ev[11]), .TX_ENABLED(lv[3]), .RX_ENABLED(lv[4])
  );

  ssim_intc_model i_ssim_intc_model (.clk(core_clk), .rst_n(rst_n), .irq(irq), .edges(edges));

  // ----------------------------------------
  // Bus and event tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_reg

  task automatic pulse(input logic [11:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 12'h000;
  endtask : pulse

  task automatic set_lv(input logic [4:0] v);
    @(posedge core_clk);
    lv <= v;
  endtask : set_lv

  // Flag lands one cycle after its cause and the line one more, so three edges is ample
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge core_clk);
    #1;
    chk("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
  endtask : irq_chk

  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    ev = 12'h000;
    lv = 5'h00;
    failures = 0;
    total_checks = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_reg(OFF_STATUS, 32'h0000_0001);
    rd_reg(OFF_MASK, 32'h0000_0000);
    set_lv(5'h1F);
    rd_reg(OFF_STATUS, 32'h0003_008B);
    set_lv(5'h08);
    rd_reg(OFF_STATUS, 32'h0001_0001);
    set_lv(5'h10);
    rd_reg(OFF_STATUS, 32'h0002_0001);
    set_lv(5'h00);
    wr_reg(OFF_IER, 32'hFFFF_FFFF);
    rd_reg(OFF_MASK, 32'h0000_0FFF);
    wr_reg(OFF_IDR, 32'hFFFF_FA5A);
    rd_reg(OFF_MASK, 32'h0000_05A5);
    wr_reg(OFF_IER, 32'h0000_0000);
    wr_reg(OFF_MASK, 32'h0000_0FFF);
    rd_reg(OFF_MASK, 32'h0000_05A5);
    wr_reg(OFF_IER, 32'h0000_0002);
    rd_reg(OFF_MASK, 32'h0000_05A7);
    rd_reg(OFF_IER, 32'h0000_0000);
    rd_reg(8'h20, 32'h0000_0000);
    wr_reg(OFF_IDR, 32'h0000_0FFF);
    rd_reg(OFF_MASK, 32'h0000_0000);
    pulse(12'hF00);
    rd_reg(OFF_STATUS, 32'h0000_0F01);
    rd_reg(OFF_STATUS, 32'h0000_0001);
    pulse(12'h001);
    rd_reg(OFF_STATUS, 32'h0000_0000);
    pulse(12'h002);
    rd_reg(OFF_STATUS, 32'h0000_0001);
    pulse(12'h010);
    rd_reg(OFF_STATUS, 32'h0000_0011);
    pulse(12'h010);
    rd_reg(OFF_STATUS, 32'h0000_0031);
    rd_reg(OFF_STATUS, 32'h0000_0011);
    pulse(12'h020);
    rd_reg(OFF_STATUS, 32'h0000_0001);
    pulse(12'h044);
    rd_reg(OFF_STATUS, 32'h0000_0045);
    rd_reg(OFF_STATUS, 32'h0000_0045);
    pulse(12'h088);
    rd_reg(OFF_STATUS, 32'h0000_0001);
    pulse(12'h100);
    wr_reg(OFF_EVCLR, 32'h0000_0100);
    rd_reg(OFF_STATUS, 32'h0000_0001);
    pulse(12'h800);
    irq_chk(1'b0);
    wr_reg(OFF_IER, 32'h0000_0800);
    irq_chk(1'b1);
    rd_reg(OFF_STATUS, 32'h0000_0801);
    irq_chk(1'b0);
    chk("irq edges", 32'h0000_0002, {24'h00_0000, edges});
    test_done();
  end
endmodule : ssim_top_tb_top
